// ---- src/mmd_map.vh ----
`ifndef MMD_MAP_VH
`define MMD_MAP_VH
// internal data space
`define MMD_IDATA_UPPER_BIT 7
`define MMD_BANK_TOP 8'h1F
`define MMD_BITBYTE_LO 8'h20
`define MMD_BITBYTE_HI 8'h2F
// external data ram: low ten bits select
`define MMD_XDATA_AW 10
// program flash
`define MMD_CODE_AW 14
`define MMD_SECTOR_SHIFT 9
`define MMD_USER_TOP 16'h3DFF
`define MMD_RSVD_BASE 16'h3E00
`define MMD_CODE_TOP 16'h3FFF
// space select codes
`define MMD_SP_IRAM 2'h0
`define MMD_SP_SPC 2'h1
`define MMD_SP_XDATA 2'h2
`define MMD_SP_CODE 2'h3
`endif

// ---- src/mmd_decoder.v ----
// Notes on behaviour
// R01: upper 128 internal bytes: indirect goes to upper ram, direct to special space.
// R02: lower 128 internal bytes reach same storage directly or indirectly.
// R03: first 32 bytes are four banks of eight working registers.
// R04: next 16 bytes are byte addressable and bit addressable.
// R05: external data ram is 1024 bytes; addresses wrap on 1 KB boundaries.
// R06: 16 KB program flash decoded from code address zero for fetch.
// R07: flash sectors are 512 bytes; sector index is address divided by 512.
// R08: top sector 0x3E00-0x3FFF is reserved; user region ends at 0x3DFF.
`include "mmd_map.vh"
`default_nettype none
module mmd_decoder #(
  // external ram address width; higher bits wrap
  parameter XDATA_AW = `MMD_XDATA_AW,
  // program flash address width
  parameter CODE_AW = `MMD_CODE_AW,
  // log2 of the flash sector size
  parameter SECTOR_SHIFT = `MMD_SECTOR_SHIFT
) (
  // clock and reset
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire i_ce,
  // core access request
  input wire i_req,
  input wire [1:0] i_space,
  input wire i_indirect,
  input wire i_bit_access,
  input wire [15:0] i_addr,
  input wire [1:0] i_bank_sel,
  // access strobe
  output wire o_valid,
  // internal data ram
  output wire o_iram_sel,
  output wire [7:0] o_iram_addr,
  output wire o_bit_mask_en,
  output wire [2:0] o_bit_pos,
  // special function space
  output wire o_spc_sel,
  output wire [6:0] o_spc_addr,
  // external data ram
  output wire o_xdata_sel,
  output wire [XDATA_AW-1:0] o_xdata_addr,
  // program flash
  output wire o_code_sel,
  output wire [CODE_AW-1:0] o_code_addr,
  output wire [CODE_AW-SECTOR_SHIFT-1:0] o_sector,
  output wire o_code_reserved,
  // nothing answers this access
  output wire o_unmapped
);

  // bit address 0x00..0x7F lands in byte 0x20 + addr[6:3]
  function [7:0] bit_byte;
    input [7:0] a;
    begin
      bit_byte = `MMD_BITBYTE_LO + {4'h0, a[6:3]};
    end
  endfunction

  // bit address 0x80..0xFF hits the space byte with low bits cleared
  function [6:0] bit_spc_byte;
    input [7:0] a;
    begin
      bit_spc_byte = {a[6:3], 3'h0};
    end
  endfunction

  // register-number form: only 0x00..0x07 follow the bank select
  function is_reg_form;
    input [7:0] a;
    begin
      is_reg_form = (a <= `MMD_BANK_TOP) && (a[7:3] == 5'h00);
    end
  endfunction

  function [7:0] bank_addr;
    input [1:0] bank;
    input [7:0] a;
    begin
      bank_addr = {3'h0, bank, a[2:0]};
    end
  endfunction

  // top sector is kept back from user code
  function in_reserved;
    input [15:0] a;
    begin
      in_reserved = (a >= `MMD_RSVD_BASE) && (a <= `MMD_CODE_TOP);
    end
  endfunction

  // fetches past the array are flagged, never aliased into it
  function beyond_flash;
    input [15:0] a;
    begin
      beyond_flash = (a > `MMD_CODE_TOP);
    end
  endfunction

  wire [7:0] ia;

  reg valid_r;
  reg iram_sel_r;
  reg [7:0] iram_addr_r;
  reg bit_mask_en_r;
  reg [2:0] bit_pos_r;
  reg spc_sel_r;
  reg [6:0] spc_addr_r;
  reg xdata_sel_r;
  reg [XDATA_AW-1:0] xdata_addr_r;
  reg code_sel_r;
  reg [CODE_AW-1:0] code_addr_r;
  reg [CODE_AW-SECTOR_SHIFT-1:0] sector_r;
  reg code_reserved_r;
  reg unmapped_r;

  reg valid_nxt;
  reg iram_sel_nxt;
  reg [7:0] iram_addr_nxt;
  reg bit_mask_en_nxt;
  reg [2:0] bit_pos_nxt;
  reg spc_sel_nxt;
  reg [6:0] spc_addr_nxt;
  reg xdata_sel_nxt;
  reg [XDATA_AW-1:0] xdata_addr_nxt;
  reg code_sel_nxt;
  reg [CODE_AW-1:0] code_addr_nxt;
  reg [CODE_AW-SECTOR_SHIFT-1:0] sector_nxt;
  reg code_reserved_nxt;
  reg unmapped_nxt;

  assign ia = i_addr[7:0];

  // address fields follow the bus every enabled cycle; only the selects qualify them
  always @* begin
    valid_nxt = i_req;
    iram_sel_nxt = 1'b0;
    iram_addr_nxt = ia;
    bit_mask_en_nxt = 1'b0;
    bit_pos_nxt = ia[2:0];
    spc_sel_nxt = 1'b0;
    spc_addr_nxt = ia[6:0];
    xdata_sel_nxt = 1'b0;
    xdata_addr_nxt = i_addr[XDATA_AW-1:0]; // R05
    code_sel_nxt = 1'b0;
    code_addr_nxt = i_addr[CODE_AW-1:0]; // R06
    sector_nxt = i_addr[CODE_AW-1:SECTOR_SHIFT]; // R07
    code_reserved_nxt = 1'b0;
    unmapped_nxt = 1'b0;
    case (i_space)
      `MMD_SP_IRAM: begin
        if (i_bit_access) begin
          if (ia[`MMD_IDATA_UPPER_BIT]) begin
            spc_sel_nxt = i_req; // R04
            spc_addr_nxt = bit_spc_byte(ia); // R04
          end else begin
            iram_sel_nxt = i_req; // R04
            iram_addr_nxt = bit_byte(ia); // R04
            bit_mask_en_nxt = i_req; // R04
          end
        end else if (ia[`MMD_IDATA_UPPER_BIT] && !i_indirect) begin
          spc_sel_nxt = i_req; // R01
        end else begin
          iram_sel_nxt = i_req; // R01 R02
          if (is_reg_form(ia)) begin
            iram_addr_nxt = bank_addr(i_bank_sel, ia); // R03
          end
        end
      end
      `MMD_SP_SPC: begin
        // direct-only space: nothing lives below 0x80 there
        if (ia[`MMD_IDATA_UPPER_BIT]) begin
          spc_sel_nxt = i_req; // R01
        end else begin
          unmapped_nxt = i_req;
        end
      end
      `MMD_SP_XDATA: begin
        xdata_sel_nxt = i_req; // R05
      end
      default: begin
        if (beyond_flash(i_addr)) begin
          unmapped_nxt = i_req; // R06
        end else begin
          code_sel_nxt = i_req; // R06
          code_reserved_nxt = i_req & in_reserved(i_addr); // R08
        end
      end
    endcase
  end

  // reset wins over the enable so a frozen block still clears
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      valid_r <= 1'b0;
      iram_sel_r <= 1'b0;
      iram_addr_r <= 8'h00;
      bit_mask_en_r <= 1'b0;
      bit_pos_r <= 3'h0;
      spc_sel_r <= 1'b0;
      spc_addr_r <= 7'h00;
      xdata_sel_r <= 1'b0;
      xdata_addr_r <= {XDATA_AW{1'b0}};
      code_sel_r <= 1'b0;
      code_addr_r <= {CODE_AW{1'b0}};
      sector_r <= {(CODE_AW-SECTOR_SHIFT){1'b0}};
      code_reserved_r <= 1'b0;
      unmapped_r <= 1'b0;
    end else if (i_ce) begin
      valid_r <= valid_nxt;
      iram_sel_r <= iram_sel_nxt;
      iram_addr_r <= iram_addr_nxt;
      bit_mask_en_r <= bit_mask_en_nxt;
      bit_pos_r <= bit_pos_nxt;
      spc_sel_r <= spc_sel_nxt;
      spc_addr_r <= spc_addr_nxt;
      xdata_sel_r <= xdata_sel_nxt;
      xdata_addr_r <= xdata_addr_nxt;
      code_sel_r <= code_sel_nxt;
      code_addr_r <= code_addr_nxt;
      sector_r <= sector_nxt;
      code_reserved_r <= code_reserved_nxt;
      unmapped_r <= unmapped_nxt;
    end
  end

  assign o_valid = valid_r;
  assign o_iram_sel = iram_sel_r;
  assign o_iram_addr = iram_addr_r;
  assign o_bit_mask_en = bit_mask_en_r;
  assign o_bit_pos = bit_pos_r;
  assign o_spc_sel = spc_sel_r;
  assign o_spc_addr = spc_addr_r;
  assign o_xdata_sel = xdata_sel_r;
  assign o_xdata_addr = xdata_addr_r;
  assign o_code_sel = code_sel_r;
  assign o_code_addr = code_addr_r;
  assign o_sector = sector_r;
  assign o_code_reserved = code_reserved_r;
  assign o_unmapped = unmapped_r;

endmodule // mmd_decoder
`default_nettype wire

// ---- verif/mmd_decoder_chk.sv ----
`default_nettype none
module mmd_chk(
  // watched
  input wire logic i_ref_clk,i_rst_n,i_ce,i_req,i_indirect,i_bit_access,
  input wire logic o_iram_sel,o_spc_sel,o_xdata_sel,o_code_sel,o_code_reserved,o_bit_mask_en,
  input wire logic [1:0] i_space,i_bank_sel,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] o_iram_addr,
  input wire logic [6:0] o_spc_addr,
  input wire logic [9:0] o_xdata_addr,
  input wire logic [13:0] o_code_addr,
  input wire logic [4:0] o_sector,
  input wire logic [2:0] o_bit_pos);
  timeunit 1ns; timeprecision 1ps;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  wire logic q=i_ce&&i_req;
  wire logic d=q&&i_space==2'h0&&!i_bit_access;
  AST_X: assert property(q&&i_space==2'h2 |=>
    o_xdata_sel&&o_xdata_addr==$past(i_addr[9:0])) else $error("external ram");
  AST_S: assert property(d&&!i_indirect&&i_addr[7] |=>
    o_spc_sel&&o_spc_addr==$past(i_addr[6:0])) else $error("special space");
  AST_U: assert property(d&&i_indirect&&i_addr[7] |=>
    o_iram_sel&&!o_spc_sel&&o_iram_addr==$past(i_addr[7:0])) else $error("upper");
  AST_L: assert property(d&&i_addr[7:5] inside {[1:3]} |=>
    o_iram_sel&&o_iram_addr==$past(i_addr[7:0])) else $error("lower");
  AST_B: assert property(d&&i_addr[7:3]==5'h0 |=>
    o_iram_addr=={3'h0,$past(i_bank_sel),$past(i_addr[2:0])}) else $error("bank");
  AST_T: assert property(q&&i_space==2'h0&&i_bit_access&&!i_addr[7] |=>
    o_bit_mask_en&&o_bit_pos==$past(i_addr[2:0])&&o_iram_addr==8'h20+$past(i_addr[6:3]))
    else $error("bit");
  AST_C: assert property(q&&i_space==2'h3&&i_addr<16'h4000 |=>
    o_code_sel&&o_code_addr==$past(i_addr[13:0])&&o_sector==$past(i_addr[13:9]))
    else $error("code");
  AST_R: assert property(q&&i_space==2'h3 |=>
    o_code_reserved==($past(i_addr[15:9])==7'h1F)) else $error("reserved");
  cover property(q&&i_space==2'h2);
  cover property(q&&i_bit_access);
  cover property(o_code_reserved);
endmodule // mmd_chk
bind mmd_decoder mmd_chk mmd_chk_i(.*);
`default_nettype wire

// ---- verif/mmd_core.sv ----
`default_nettype none
module mmd_core(
  input wire logic i_ref_clk,
  output logic i_req,i_indirect,i_bit_access,
  output logic [1:0] i_space,i_bank_sel,
  output logic [15:0] i_addr);
  timeunit 1ns; timeprecision 1ps;
  initial {i_req,i_space,i_indirect,i_bit_access,i_addr,i_bank_sel}=23'h0;
  task automatic acc(input logic [21:0] v);
    @(posedge i_ref_clk);
    #1 {i_space,i_indirect,i_bit_access,i_addr,i_bank_sel}=v;
    i_req=1;
  endtask
  // idle address flips so a stale value never looks valid
  task automatic idle;
    @(posedge i_ref_clk);
    #1 i_req=0;
    i_addr=~i_addr;
  endtask
endmodule // mmd_core
`default_nettype wire

// ---- verif/test_mmd_decoder.sv ----
`default_nettype none
module test_mmd_decoder;
  timeunit 1ns; timeprecision 1ps;
  logic i_ref_clk=0,i_rst_n=0,i_ce=1;
  int n_fail=0,samples_checked=0;
  wire logic i_req,i_indirect,i_bit_access,o_valid,o_iram_sel,o_spc_sel,o_xdata_sel,o_code_sel;
  wire logic o_code_reserved,o_bit_mask_en,o_unmapped;
  wire logic [1:0] i_space,i_bank_sel;
  wire logic [15:0] i_addr;
  wire logic [7:0] o_iram_addr;
  wire logic [6:0] o_spc_addr;
  wire logic [9:0] o_xdata_addr;
  wire logic [13:0] o_code_addr;
  wire logic [4:0] o_sector;
  wire logic [2:0] o_bit_pos;
  wire logic [23:0] ob={o_valid,o_iram_sel,o_spc_sel,o_xdata_sel,o_code_sel,o_code_reserved,
    o_bit_mask_en,o_unmapped,o_iram_sel?{o_bit_mask_en?o_bit_pos:3'h0,5'h0,o_iram_addr}:
    o_spc_sel?{9'h0,o_spc_addr}:o_xdata_sel?{6'h0,o_xdata_addr}:
    o_code_sel?{2'h0,o_code_addr}:16'h0};
  // rows: space, indirect/bit, addr, bank | flags, selected address
  logic [45:0] t[12]='{{2'h2,2'h0,16'h0805,2'h0,8'h90,16'h0005},
    {2'h2,2'h0,16'hFFFF,2'h0,8'h90,16'h03FF},{2'h0,2'h0,16'h0090,2'h0,8'hA0,16'h0010},
    {2'h0,2'h2,16'h0090,2'h0,8'hC0,16'h0090},{2'h0,2'h0,16'h0045,2'h0,8'hC0,16'h0045},
    {2'h0,2'h0,16'h0003,2'h2,8'hC0,16'h0013},{2'h0,2'h1,16'h000B,2'h0,8'hC2,16'h6021},
    {2'h3,2'h0,16'h3E10,2'h0,8'h8C,16'h3E10},{2'h3,2'h0,16'h4000,2'h0,8'h81,16'h0000},
    {2'h1,2'h0,16'h0085,2'h0,8'hA0,16'h0005},{2'h1,2'h0,16'h0005,2'h0,8'h81,16'h0000},
    {2'h3,2'h0,16'h3DFF,2'h0,8'h88,16'h3DFF}};
  always #4 i_ref_clk=~i_ref_clk;
  mmd_core mmd_core_i(.*);
  mmd_decoder mmd_decoder_i(.*);
  task automatic chk(input logic [23:0] g,e);
    samples_checked++;
    if (g!==e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h",$time,g,e);
    end
  endtask
  task automatic chk_sec(input logic [4:0] g,e);
    samples_checked++;
    if (g!==e) begin
      n_fail++;
      $display("[ERR] %0t sector got %h exp %h",$time,g,e);
    end
  endtask
  task automatic print_verdict;
    $display("checked %0d failed %0d",samples_checked,n_fail);
    if (n_fail==0&&samples_checked>0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #2000 n_fail++;
    print_verdict;
  end
  initial begin
    repeat(16) @(posedge i_ref_clk);
    #1 i_rst_n=1;
    // back to back: each edge answers the previous row
    for (int i=0;i<=12;i++) begin
      if (i<12) mmd_core_i.acc(t[i][45:24]);
      else mmd_core_i.idle;
      if (i>0) chk(ob,t[i-1][23:0]);
    end
    $display("table done");
    i_ce=0;
    mmd_core_i.acc({2'h2,2'h0,16'h0123,2'h0});
    @(posedge i_ref_clk) #1 chk(ob,t[11][23:0]);
    i_ce=1;
    @(posedge i_ref_clk) #1 chk(ob,{8'h90,16'h0123});
    $display("enable done");
    i_rst_n=0;
    @(posedge i_ref_clk) #1 chk(ob,24'h0);
    i_rst_n=1;
    mmd_core_i.acc({2'h3,2'h0,16'h0200,2'h0});
    mmd_core_i.idle;
    chk(ob,{8'h88,16'h0200});
    chk_sec(o_sector,5'h01);
    $display("reset done");
    print_verdict;
  end
endmodule // test_mmd_decoder
`default_nettype wire
